/* File: hw/apd_pkg.sv */
package apd_pkg;
  // Floppy register offsets (host address bits 2:0)
  localparam logic [2:0] OFS_STATUS_A = 3'h0;
  localparam logic [2:0] OFS_STATUS_B = 3'h1;
  localparam logic [2:0] OFS_DOR = 3'h2;
  localparam logic [2:0] OFS_DSR_MSR = 3'h4;
  localparam logic [2:0] OFS_FIFO = 3'h5;
  localparam logic [2:0] OFS_DIR_CCR = 3'h7;
  // Field positions
  localparam int DOR_MOTOR_LSB = 4;
  localparam int DOR_RESET_N_BIT = 2;
  localparam int DSR_SWRESET_BIT = 7;
  localparam int SER_PD_A_BIT = 3;
  localparam int SER_PD_B_BIT = 7;
  localparam int PWR_PAR_AUTO_BIT = 4;
  localparam int PWR_SER_A_AUTO_BIT = 5;
  localparam int PWR_SER_B_AUTO_BIT = 6;
  localparam int PWR_FDC_AUTO_BIT = 7;
  localparam int PAR_PD_BIT = 2;
  // Idle main status value
  localparam logic [7:0] MSR_IDLE = 8'h80;
  // Extended control mode field values
  localparam logic [2:0] ECR_MODE_SPP = 3'h0;
  localparam logic [2:0] ECR_MODE_PS2 = 3'h1;
  localparam logic [2:0] ECR_MODE_EPP = 3'h4;
  // Parallel mode configuration
  localparam logic [1:0] PMODE_EPP = 2'h1;
  localparam logic [1:0] PMODE_ECP = 2'h2;
  localparam logic [1:0] PMODE_ECP_EPP = 2'h3;
  // Reset values
  localparam logic [7:0] DOR_RESET = 8'h00;
  localparam logic [7:0] DSR_RESET = 8'h02;
  localparam logic [7:0] CCR_RESET = 8'h02;
  // Powerdown timer
  localparam int CLK_HZ = 100_000_000;
  localparam int PD_TIME_MS = 10;
  localparam int PD_CYCLES = CLK_HZ / 1000 * PD_TIME_MS;
  typedef enum logic [1:0] {
    FDC_AWAKE = 2'b00,
    FDC_COUNT = 2'b01,
    FDC_DOWN = 2'b11
  } fdc_state_t;
endpackage : apd_pkg

/* File: hw/serial_port_pd.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_pd (
  input wire logic i_clk,              // Device clock
  input wire logic i_rst_n,            // Async reset, active low
  input wire logic i_direct_pd,        // Direct powerdown bit
  input wire logic i_auto_en,          // Auto powerdown enable
  input wire logic i_thr_empty,        // Holding buffer empty
  input wire logic i_tsr_empty,        // Shift register empty
  input wire logic i_rx_fifo_empty,    // Receive FIFO empty
  input wire logic i_rx_idle,          // Waiting for start bit
  input wire logic i_thr_write,        // Host write to holding buffer
  input wire logic i_rx_raw,           // Receive data pin
  input wire logic i_ri_raw,           // Ring indicate pin
  output logic o_tx_pd,                // Transmitter powered down
  output logic o_rx_pd,                // Receiver powered down
  output logic o_ri_change             // Ring indicate changed, pulse
);
  typedef struct packed {
    logic [1:0] rx_sync;
    logic [1:0] ri_sync;
    logic rx_last;
    logic ri_last;
    logic tx_pd;
    logic rx_pd;
    logic ri_change;
  } ser_state_t;
  ser_state_t q, d;
  logic rx_edge;
  always_comb begin
    d = q;
    d.rx_sync = {q.rx_sync[0], i_rx_raw};
    d.ri_sync = {q.ri_sync[0], i_ri_raw};
    d.rx_last = q.rx_sync[1];
    d.ri_last = q.ri_sync[1];
    rx_edge = q.rx_sync[1] ^ q.rx_last;
    d.ri_change = q.ri_sync[1] ^ q.ri_last;
    if (i_direct_pd) begin
      d.tx_pd = 1'b1;
    end else if (!i_auto_en || i_thr_write) begin
      d.tx_pd = 1'b0;
    end else if (i_thr_empty && i_tsr_empty) begin
      d.tx_pd = 1'b1;
    end
    if (i_direct_pd) begin
      d.rx_pd = 1'b1;
    end else if (!i_auto_en || rx_edge) begin
      d.rx_pd = 1'b0;
    end else if (i_rx_fifo_empty && i_rx_idle) begin
      d.rx_pd = 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Idle-high pins, so no false edge right after reset
      q <= '{rx_sync: 2'h3, ri_sync: 2'h3, rx_last: 1'b1, ri_last: 1'b1,
             tx_pd: 1'b0, rx_pd: 1'b0, ri_change: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign o_tx_pd = q.tx_pd;
  assign o_rx_pd = q.rx_pd;
  assign o_ri_change = q.ri_change;
endmodule : serial_port_pd
`default_nettype wire

/* File: hw/super_io_auto_powerdown_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module super_io_auto_powerdown_ctrl #(
  parameter int PD_CYCLES = apd_pkg::PD_CYCLES
) (
  input wire logic i_clk,                    // Device clock, 100 MHz
  input wire logic i_rst_n,                  // Async reset, active low
  input wire logic i_rd,                     // Decoded floppy read strobe, one cycle
  input wire logic i_wr,                     // Decoded floppy write strobe, one cycle
  input wire logic [2:0] i_addr,             // Floppy register offset
  input wire logic [7:0] i_wdata,            // Host write data
  input wire logic [7:0] i_main_status,      // Main status from core
  input wire logic i_core_irq,               // Core interrupt pending
  input wire logic i_head_unloaded,          // Head unload timer expired
  input wire logic [7:0] i_power_config_reg, // Power configuration register
  input wire logic [7:0] i_serial_config_reg,   // Serial configuration register
  input wire logic [7:0] i_parallel_config_reg, // Parallel configuration register
  input wire logic [1:0] i_par_mode_cfg,     // Parallel mode configuration
  input wire logic [2:0] i_ecr_mode,         // Extended control mode field
  input wire logic [3:0] i_motor_on,         // Core motor enables
  input wire logic [3:0] i_drive_select,     // Core drive selects
  input wire logic i_write_bitstream,        // Core write data
  input wire logic i_write_gate,             // Core write gate
  input wire logic i_step,                   // Core step
  input wire logic i_dir,                    // Core direction
  input wire logic i_head_side,              // Core head select
  input wire logic i_density_select,         // Core density select
  input wire logic [1:0] i_rate_code,        // Core rate code
  input wire logic i_track_zero_in,          // Drive pin
  input wire logic i_index_pulse_in,         // Drive pin
  input wire logic i_media_changed_in,       // Drive pin
  input wire logic i_second_drive_in,        // Drive pin
  input wire logic [1:0] i_thr_empty,        // Per UART holding empty
  input wire logic [1:0] i_tsr_empty,        // Per UART shift empty
  input wire logic [1:0] i_rx_fifo_empty,    // Per UART receive FIFO empty
  input wire logic [1:0] i_rx_idle,          // Per UART receiver idle
  input wire logic [1:0] i_thr_write,        // Per UART holding write
  input wire logic [1:0] i_serial_rx_in,     // Per UART receive pin
  input wire logic [1:0] i_ring_indicate_in, // Per UART ring pin
  output logic o_fdc_pd,                     // Floppy powered down
  output logic o_fdc_wake,                   // Wake pulse to core
  output logic [7:0] o_dor_held,             // Retained output control
  output logic [7:0] o_dsr_held,             // Retained rate select
  output logic [7:0] o_ccr_held,             // Retained config control
  output logic [3:0] o_motor_on_out,         // Motor enables
  output logic [3:0] o_motor_on_oe,          // Motor enables drive
  output logic [3:0] o_drive_select_out,     // Drive selects
  output logic [3:0] o_drive_select_oe,      // Drive selects drive
  output logic o_write_bitstream_out,        // Write data
  output logic o_write_bitstream_oe,         // Write data drive
  output logic o_write_gate_out,             // Write gate
  output logic o_write_gate_oe,              // Write gate drive
  output logic o_step_out,                   // Step
  output logic o_dir_out,                    // Direction
  output logic o_head_side_out,              // Head select
  output logic o_density_select_out,         // Density select
  output logic [1:0] o_rate_code_out,        // Rate code
  output logic [3:0] o_drive_in_gated,       // Gated drive status
  output logic [1:0] o_tx_pd,                // Transmitter powered down
  output logic [1:0] o_rx_pd,                // Receiver powered down
  output logic [1:0] o_ri_change,            // Ring change pulse
  output logic o_par_pd,                     // Parallel direct powerdown
  output logic o_epp_pd,                     // EPP logic powered down
  output logic o_ecp_pd                      // ECP logic powered down
);
  // Timer needs at least two counts to restart cleanly
  if (PD_CYCLES < 2) begin : g_bad_pd_cycles
    $error("PD_CYCLES too small");
  end
  localparam int CW = $clog2(PD_CYCLES + 1);
  typedef struct packed {
    apd_pkg::fdc_state_t st;
    logic [CW-1:0] cnt;
    logic wake;
    logic [7:0] drive_output_control;
    logic [7:0] dsr;
    logic [7:0] rate_config_control;
    logic [3:0] mot;
    logic [3:0] mot_oe;
    logic [3:0] ds;
    logic [3:0] ds_oe;
    logic wd;
    logic wd_oe;
    logic wg;
    logic wg_oe;
    logic step;
    logic dir;
    logic hs;
    logic dens;
    logic [1:0] rate;
    logic [3:0] din_s1;
    logic [3:0] din_s2;
    logic [3:0] din_g;
    logic par_pd;
    logic epp_pd;
    logic ecp_pd;
  } ctl_state_t;
  ctl_state_t q, d;
  logic wake_req;
  logic fdc_auto;
  logic sleep_ok;
  logic ecp_cfg;
  logic epp_cfg;
  always_comb begin
    d = q;
    fdc_auto = i_power_config_reg[apd_pkg::PWR_FDC_AUTO_BIT];
    wake_req = (i_rd && i_addr == apd_pkg::OFS_DSR_MSR)
      || ((i_rd || i_wr) && i_addr == apd_pkg::OFS_FIFO)
      || (i_wr && i_addr == apd_pkg::OFS_DOR
          && (|i_wdata[apd_pkg::DOR_MOTOR_LSB +: 4] || !i_wdata[apd_pkg::DOR_RESET_N_BIT]))
      || (i_wr && i_addr == apd_pkg::OFS_DSR_MSR && i_wdata[apd_pkg::DSR_SWRESET_BIT]);
    if (i_wr && i_addr == apd_pkg::OFS_DOR) begin
      d.drive_output_control = i_wdata;
    end
    if (i_wr && i_addr == apd_pkg::OFS_DSR_MSR) begin
      d.dsr = i_wdata;
    end
    if (i_wr && i_addr == apd_pkg::OFS_DIR_CCR) begin
      d.rate_config_control = i_wdata;
    end
    sleep_ok = (i_motor_on == 4'h0) && (i_main_status == apd_pkg::MSR_IDLE)
      && !i_core_irq && i_head_unloaded;
    d.wake = 1'b0;
    case (q.st)
      apd_pkg::FDC_AWAKE: begin
        d.cnt = '0;
        if (fdc_auto) begin
          d.st = apd_pkg::FDC_COUNT;
        end
      end
      apd_pkg::FDC_COUNT: begin
        if (!fdc_auto) begin
          d.st = apd_pkg::FDC_AWAKE;
        end else if (wake_req) begin
          d.cnt = '0;
        end else if (q.cnt < CW'(PD_CYCLES)) begin
          d.cnt = q.cnt + CW'(1);
        end else if (sleep_ok) begin
          d.st = apd_pkg::FDC_DOWN;
        end
      end
      apd_pkg::FDC_DOWN: begin
        if (wake_req || !fdc_auto) begin
          d.st = fdc_auto ? apd_pkg::FDC_COUNT : apd_pkg::FDC_AWAKE;
          d.cnt = '0;
          d.wake = wake_req;
        end
      end
      default: begin
        d.st = apd_pkg::FDC_AWAKE;
      end
    endcase
    d.mot = i_motor_on;
    d.ds = i_drive_select;
    d.wd = i_write_bitstream;
    d.wg = i_write_gate;
    d.mot_oe = {4{d.st != apd_pkg::FDC_DOWN}};
    d.ds_oe = {4{d.st != apd_pkg::FDC_DOWN}};
    d.wd_oe = d.st != apd_pkg::FDC_DOWN;
    d.wg_oe = d.st != apd_pkg::FDC_DOWN;
    d.step = i_step;
    d.dir = i_dir;
    d.hs = i_head_side;
    d.dens = i_density_select;
    d.rate = i_rate_code;
    d.din_s1 = {i_second_drive_in, i_media_changed_in, i_index_pulse_in, i_track_zero_in};
    d.din_s2 = q.din_s1;
    d.din_g = (q.st == apd_pkg::FDC_DOWN) ? 4'h0 : q.din_s2;
    d.par_pd = i_parallel_config_reg[apd_pkg::PAR_PD_BIT];
    ecp_cfg = (i_par_mode_cfg == apd_pkg::PMODE_ECP) || (i_par_mode_cfg == apd_pkg::PMODE_ECP_EPP);
    epp_cfg = (i_par_mode_cfg == apd_pkg::PMODE_EPP) || (i_par_mode_cfg == apd_pkg::PMODE_ECP_EPP);
    if (i_power_config_reg[apd_pkg::PWR_PAR_AUTO_BIT]) begin
      d.epp_pd = !epp_cfg || (ecp_cfg && i_ecr_mode != apd_pkg::ECR_MODE_EPP);
      d.ecp_pd = !ecp_cfg || i_ecr_mode == apd_pkg::ECR_MODE_SPP
        || i_ecr_mode == apd_pkg::ECR_MODE_PS2 || i_ecr_mode == apd_pkg::ECR_MODE_EPP;
    end else begin
      d.epp_pd = 1'b0;
      d.ecp_pd = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= apd_pkg::FDC_AWAKE;
      q.drive_output_control <= apd_pkg::DOR_RESET;
      q.dsr <= apd_pkg::DSR_RESET;
      q.rate_config_control <= apd_pkg::CCR_RESET;
      q.mot_oe <= 4'hf;
      q.ds_oe <= 4'hf;
      q.wd_oe <= 1'b1;
      q.wg_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_uart
      serial_port_pd u_pd (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_direct_pd(i_serial_config_reg[g == 0 ? apd_pkg::SER_PD_A_BIT : apd_pkg::SER_PD_B_BIT]),
        .i_auto_en(i_power_config_reg[g == 0 ? apd_pkg::PWR_SER_A_AUTO_BIT : apd_pkg::PWR_SER_B_AUTO_BIT]),
        .i_thr_empty(i_thr_empty[g]),
        .i_tsr_empty(i_tsr_empty[g]),
        .i_rx_fifo_empty(i_rx_fifo_empty[g]),
        .i_rx_idle(i_rx_idle[g]),
        .i_thr_write(i_thr_write[g]),
        .i_rx_raw(i_serial_rx_in[g]),
        .i_ri_raw(i_ring_indicate_in[g]),
        .o_tx_pd(o_tx_pd[g]),
        .o_rx_pd(o_rx_pd[g]),
        .o_ri_change(o_ri_change[g])
      );
    end
  endgenerate
  assign o_fdc_pd = q.st == apd_pkg::FDC_DOWN;
  assign o_fdc_wake = q.wake;
  assign o_dor_held = q.drive_output_control;
  assign o_dsr_held = q.dsr;
  assign o_ccr_held = q.rate_config_control;
  assign o_motor_on_out = q.mot;
  assign o_motor_on_oe = q.mot_oe;
  assign o_drive_select_out = q.ds;
  assign o_drive_select_oe = q.ds_oe;
  assign o_write_bitstream_out = q.wd;
  assign o_write_bitstream_oe = q.wd_oe;
  assign o_write_gate_out = q.wg;
  assign o_write_gate_oe = q.wg_oe;
  assign o_step_out = q.step;
  assign o_dir_out = q.dir;
  assign o_head_side_out = q.hs;
  assign o_density_select_out = q.dens;
  assign o_rate_code_out = q.rate;
  assign o_drive_in_gated = q.din_g;
  assign o_par_pd = q.par_pd;
  assign o_epp_pd = q.epp_pd;
  assign o_ecp_pd = q.ecp_pd;
endmodule : super_io_auto_powerdown_ctrl
`default_nettype wire

/* File: test/apd_props.sv */
`timescale 1ns/1ps
`default_nettype none
module apd_props #(
  parameter int PD_CYCLES = 20
) (
  input wire logic i_clk, i_rst_n, i_rd, i_wr, i_core_irq, i_head_unloaded, i_step,
  input wire logic [2:0] i_addr, i_ecr_mode,
  input wire logic [7:0] i_wdata, i_main_status, i_power_config_reg, i_serial_config_reg,
  input wire logic [7:0] i_parallel_config_reg,
  input wire logic [1:0] i_par_mode_cfg, i_rate_code, i_thr_empty, i_tsr_empty,
  input wire logic [1:0] i_thr_write, i_serial_rx_in, i_ring_indicate_in,
  input wire logic [3:0] i_motor_on,
  input wire logic o_fdc_pd, o_fdc_wake, o_write_gate_oe, o_write_bitstream_oe, o_step_out,
  input wire logic [3:0] o_motor_on_oe, o_drive_select_oe, o_drive_in_gated,
  input wire logic [1:0] o_rate_code_out, o_tx_pd, o_rx_pd, o_ri_change,
  input wire logic o_par_pd, o_epp_pd, o_ecp_pd
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wake_by_access_a: assert property (
    o_fdc_pd && i_rd && i_addr inside {3'h4, 3'h5} |=> !o_fdc_pd && o_fdc_wake)
    else $error("status or fifo read left floppy asleep");
  quiet_access_a: assert property (
    o_fdc_pd && i_power_config_reg[7] && (i_rd && i_addr inside {3'h0, 3'h1, 3'h2, 3'h7} ||
    i_wr && (i_addr == 3'h7 || i_addr == 3'h2 && i_wdata[7:4] == 4'h0 && i_wdata[2] ||
    i_addr == 3'h4 && !i_wdata[7])) |=> o_fdc_pd)
    else $error("quiet access woke floppy");
  drive_pins_off_a: assert property (
    o_fdc_pd && $past(o_fdc_pd) |-> {o_motor_on_oe, o_drive_select_oe, o_write_gate_oe,
    o_write_bitstream_oe, o_drive_in_gated} == 14'h0)
    else $error("drive pins active while asleep");
  local_active_a: assert property (
    1 |=> o_step_out == $past(i_step) && o_rate_code_out == $past(i_rate_code))
    else $error("local control outputs not following core");
  sleep_idle_a: assert property (
    $rose(o_fdc_pd) |-> $past(i_motor_on == 4'h0 && i_main_status == 8'h80 && !i_core_irq && i_head_unloaded))
    else $error("floppy slept while busy");
  tx_auto_down_a: assert property (
    i_power_config_reg[5] && !i_serial_config_reg[3] && i_thr_empty[0] && i_tsr_empty[0] &&
    !i_thr_write[0] |=> o_tx_pd[0])
    else $error("idle transmitter stayed up");
  tx_wake_a: assert property (
    i_thr_write[0] && !i_serial_config_reg[3] |=> !o_tx_pd[0])
    else $error("holding write did not wake transmitter");
  serial_direct_a: assert property (
    i_serial_config_reg[7] |=> o_tx_pd[1] && o_rx_pd[1])
    else $error("serial direct powerdown ignored");
  ring_follow_a: assert property (
    $changed(i_ring_indicate_in[0]) |-> ##[1:4] o_ri_change[0])
    else $error("ring change not reported");
  rx_wake_a: assert property (
    o_rx_pd[1] && !i_serial_config_reg[7] && $changed(i_serial_rx_in[1]) |-> ##[1:5] !o_rx_pd[1])
    else $error("receive edge did not wake receiver");
  par_modes_a: assert property (
    i_power_config_reg[4] |=> o_ecp_pd == $past(!i_par_mode_cfg[1] || i_ecr_mode inside {3'h0, 3'h1, 3'h4})
    && o_epp_pd == $past(!i_par_mode_cfg[0] || i_par_mode_cfg[1] && i_ecr_mode != 3'h4))
    else $error("parallel sub-block power wrong");
  par_direct_a: assert property (
    1 |=> o_par_pd == $past(i_parallel_config_reg[2]))
    else $error("parallel direct powerdown wrong");
  cover property ($rose(o_fdc_pd));
  cover property (o_fdc_wake);
  cover property ($rose(o_tx_pd[0]));
endmodule : apd_props
bind super_io_auto_powerdown_ctrl apd_props #(.PD_CYCLES(PD_CYCLES)) apd_props_inst (.*);
`default_nettype wire

/* File: test/host_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic i_clk,     // Device clock
  output logic o_rd,          // Read strobe
  output logic o_wr,          // Write strobe
  output logic [2:0] o_addr,  // Register offset
  output logic [7:0] o_wdata  // Write data
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  // Released address and data lines show the inverse, not a stale value; both strobes return low
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_rd = !w;
    o_wr = w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : acc
endmodule : host_bus_model
`default_nettype wire

/* File: test/super_io_auto_powerdown_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module super_io_auto_powerdown_ctrl_tb;
  localparam int PDC = 20;
  logic i_clk, i_rst_n, i_rd, i_wr, i_core_irq, i_head_unloaded, i_write_bitstream, i_write_gate;
  logic i_step, i_dir, i_head_side, i_density_select;
  logic i_track_zero_in, i_index_pulse_in, i_media_changed_in, i_second_drive_in;
  logic [2:0] i_addr, i_ecr_mode;
  logic [7:0] i_wdata, i_main_status, i_power_config_reg, i_serial_config_reg, i_parallel_config_reg;
  logic [1:0] i_par_mode_cfg, i_rate_code, i_thr_empty, i_tsr_empty, i_rx_fifo_empty, i_rx_idle;
  logic [1:0] i_thr_write, i_serial_rx_in, i_ring_indicate_in, o_rate_code_out, o_tx_pd, o_rx_pd, o_ri_change;
  logic [3:0] i_motor_on, i_drive_select, o_motor_on_out, o_motor_on_oe, o_drive_select_out;
  logic [3:0] o_drive_select_oe, o_drive_in_gated;
  logic o_fdc_pd, o_fdc_wake, o_write_bitstream_out, o_write_bitstream_oe, o_write_gate_out;
  logic o_write_gate_oe, o_step_out, o_dir_out, o_head_side_out, o_density_select_out;
  logic o_par_pd, o_epp_pd, o_ecp_pd;
  logic [7:0] o_dor_held, o_dsr_held, o_ccr_held;
  logic [11:0] nw [7];
  logic [11:0] wk [6];
  int err_count, n_compared, i, n;
  super_io_auto_powerdown_ctrl #(.PD_CYCLES(PDC)) super_io_auto_powerdown_ctrl_inst (.*);
  host_bus_model host_bus_model_inst (.i_clk(i_clk), .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc
  task automatic wait_pd(input logic lvl);
    n = 0;
    while (o_fdc_pd !== lvl && n < 60) begin
      cyc(1);
      n++;
    end
  endtask : wait_pd
  initial begin
    #100us;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    {i_rst_n, i_core_irq, i_head_unloaded, i_write_bitstream, i_write_gate, i_step, i_dir, i_head_side,
      i_density_select, i_ecr_mode, i_power_config_reg, i_serial_config_reg, i_parallel_config_reg,
      i_par_mode_cfg, i_rate_code, i_thr_write, i_motor_on, i_drive_select} = '0;
    i_main_status = 8'h80;
    {i_track_zero_in, i_index_pulse_in, i_media_changed_in, i_second_drive_in} = 4'hf;
    {i_thr_empty, i_tsr_empty, i_rx_fifo_empty, i_rx_idle, i_serial_rx_in, i_ring_indicate_in} = '1;
    nw = '{12'h000, 12'h100, 12'h200, 12'h700, 12'hf55, 12'ha04, 12'hc01};
    wk = '{12'h400, 12'h500, 12'hd3c, 12'ha14, 12'ha00, 12'hc80};
    cyc(12);
    i_rst_n = 1'b1;
    cyc(3);
    chk({o_dor_held, o_dsr_held, o_ccr_held, o_drive_in_gated, o_fdc_pd}, 29'h000405e);
    chk(o_ri_change, 2'h0);
    i_power_config_reg = 8'h80;
    cyc(PDC + 10);
    chk(o_fdc_pd, 1'b0);
    i_power_config_reg = 8'h00;
    i_head_unloaded = 1'b1;
    cyc(1);
    i_power_config_reg = 8'h80;
    wait_pd(1'b1);
    chk(n >= PDC && n < PDC + 5, 1'b1);
    cyc(1);
    chk({o_motor_on_oe, o_drive_select_oe, o_write_gate_oe, o_write_bitstream_oe, o_drive_in_gated}, 0);
    i_step = 1'b1;
    i_rate_code = 2'h3;
    i_dir = 1'b1;
    i_head_side = 1'b1;
    i_density_select = 1'b1;
    cyc(2);
    chk({o_step_out, o_rate_code_out}, 3'h7);
    chk({o_dir_out, o_head_side_out, o_density_select_out}, 3'h7);
    chk({o_motor_on_out, o_drive_select_out, o_write_bitstream_out, o_write_gate_out}, 10'h000);
    $display("test sleep done");
    for (i = 0; i < 7; i++) begin
      host_bus_model_inst.acc(nw[i][11], nw[i][10:8], nw[i][7:0]);
      chk({o_fdc_pd, o_fdc_wake}, 2'b10);
    end
    chk({o_dor_held, o_dsr_held, o_ccr_held}, 24'h040155);
    $display("test quiet access done");
    for (i = 0; i < 6; i++) begin
      wait_pd(1'b1);
      chk(o_fdc_pd, 1'b1);
      host_bus_model_inst.acc(wk[i][11], wk[i][10:8], wk[i][7:0]);
      chk({o_fdc_pd, o_fdc_wake}, 2'b01);
      cyc(1);
      chk({o_fdc_wake, o_motor_on_oe}, 5'h0f);
    end
    chk(o_dsr_held, 8'h80);
    i_power_config_reg = 8'h00;
    cyc(2);
    chk(o_fdc_pd, 1'b0);
    $display("test wake done");
    i_thr_empty[0] = 1'b0;
    i_rx_idle[1] = 1'b0;
    i_power_config_reg = 8'h60;
    cyc(3);
    chk({o_tx_pd, o_rx_pd}, 4'h9);
    i_thr_empty[0] = 1'b1;
    i_rx_idle[1] = 1'b1;
    cyc(2);
    chk({o_tx_pd, o_rx_pd}, 4'hf);
    i_thr_write[0] = 1'b1;
    cyc(1);
    i_thr_write[0] = 1'b0;
    chk(o_tx_pd[0], 1'b0);
    i_serial_rx_in[1] = 1'b0;
    n = 0;
    while (o_rx_pd[1] !== 1'b0 && n < 6) begin
      cyc(1);
      n++;
    end
    chk(o_rx_pd[1], 1'b0);
    i_ring_indicate_in[0] = 1'b0;
    n = 0;
    while (o_ri_change[0] !== 1'b1 && n < 6) begin
      cyc(1);
      n++;
    end
    chk(o_ri_change[0], 1'b1);
    i_power_config_reg = 8'h00;
    i_serial_config_reg = 8'h80;
    cyc(2);
    chk({o_tx_pd, o_rx_pd}, 4'ha);
    i_serial_config_reg = 8'h08;
    cyc(2);
    chk({o_tx_pd, o_rx_pd}, 4'h5);
    $display("test serial done");
    i_power_config_reg = 8'h10;
    for (i = 0; i < 16; i++) begin
      i_par_mode_cfg = i[1:0];
      i_ecr_mode = (i[3:2] == 2'h2) ? 3'h4 : {1'b0, i[3:2]};
      i_parallel_config_reg = {5'h00, i[0], 2'h0};
      cyc(2);
      chk({o_par_pd, o_epp_pd, o_ecp_pd}, {i[0], !i[0] || i[1] && i_ecr_mode != 3'h4,
        !i[1] || i_ecr_mode inside {3'h0, 3'h1, 3'h4}});
    end
    i_power_config_reg = 8'h00;
    cyc(2);
    chk({o_epp_pd, o_ecp_pd}, 2'b00);
    $display("test parallel done");
    final_report();
  end
endmodule : super_io_auto_powerdown_ctrl_tb
`default_nettype wire
